// [src/rxl_cfg.svh]
`ifndef RXL_CFG_SVH
`define RXL_CFG_SVH

// link geometry
`define RXL_NSLICE 4
`define RXL_FRAG_W 256
`define RXL_GRAN_W 32
`define RXL_GPF_MAX 8
`define RXL_LLP_GRAN 16
`define RXL_DSK_DEPTH 4

// header field positions (within a corrected 32-bit granule)
`define RXL_TYPE_LSB 5
`define RXL_STRM_LSB 9
`define RXL_LEN_LSB 12
`define RXL_MARK_LSB 17

`endif

// [src/rxl_pkg.sv]
package rxl_pkg;

    typedef enum logic [1:0] {
        ST_QUIET = 2'b00,
        ST_ALIGN = 2'b01,
        ST_RUN = 2'b10
    } rxl_state_t;

    typedef enum logic [1:0] {
        TT_IDLE = 2'b00,
        TT_DATA = 2'b01,
        TT_CREDIT = 2'b10,
        TT_VWIRE = 2'b11
    } rxl_ttype_t;

    typedef enum logic [1:0] {
        FW_64 = 2'b00,
        FW_128 = 2'b01,
        FW_256 = 2'b10
    } rxl_fw_t;

    typedef enum logic [1:0] {
        NS_1 = 2'b00,
        NS_2 = 2'b01,
        NS_4 = 2'b10
    } rxl_ns_t;

endpackage : rxl_pkg

// [src/rxl_top.sv]
`timescale 1ns/100ps
`include "rxl_cfg.svh"
// How it works
// - deskew buffer aligns slice fragments into bundles
// - all bundle types but 4x256, transmitter granule order
// - decode link header first, start marks
// - correct link header before using marks
// - correct txn header, steer by type
// - virtual wire packets go to wire logic
// - credit packets go to local transmitter
// - idle fillers between packets are dropped
// - correct payload, deliver only when complete
// - training after reset aligns phase, skew
// - 32-bit granules, up to eight per fragment
// - phase ok when value mod count equals index
// - two granules: low bits 0 then 1
// - four granules: low bits 0 to 3
// - eight granules: low bits 0 to 7
// - skew places bundle granules together
// - one, two, four slices; no 4x256
// - link header in fragment zero bits 31:0
// - quiet state ignores fragments, others capture
// - skew from byte zero, wrap safe
module rxl_top (
    // core
    input wire logic i_clk,
    input wire logic i_rst_b,
    // configuration and control
    input wire logic [1:0] i_frag_w,
    input wire logic [1:0] i_slices,
    input wire logic i_link_on,
    input wire logic i_train_done,
    input wire logic [7:0] i_slice_dly,
    // fragments from the slices
    input wire logic i_lnk_clk,
    input wire logic [1023:0] i_frag,
    // training results
    output logic [1:0] o_state,
    output logic [3:0] o_phase_ok,
    output logic [31:0] o_skew,
    // unpacked traffic
    output logic o_tlp_valid,
    output logic [2:0] o_tlp_stream,
    output logic [4:0] o_tlp_len,
    output logic [511:0] o_tlp_data,
    output logic o_credit_valid,
    output logic [31:0] o_credit_data,
    output logic o_vw_valid,
    output logic [31:0] o_vw_data
);

    // single-error fix: syndrome is the xor of positions of set bits
    function automatic logic [4:0] rxl_syn(input logic [31:0] w);
        logic [4:0] s;
        s = 5'h00;
        for (int i = 1; i < 32; i++) begin
            if (w[i]) begin
                s = s ^ 5'(i);
            end
        end
        return s;
    endfunction : rxl_syn

    function automatic logic [31:0] rxl_fix(input logic [31:0] w);
        logic [4:0] s;
        logic [31:0] r;
        s = rxl_syn(w);
        r = w;
        if (s != 5'h00) begin
            r[s] = ~w[s];
        end
        return r;
    endfunction : rxl_fix

    // link capture and deskew
    logic lclk_s1_r, lclk_s2_r, lclk_s3_r;
    logic [1023:0] frag_s1_r, frag_s2_r;
    logic take_r, take_nxt;
    rxl_pkg::rxl_state_t st_r, st_nxt;
    logic [255:0] dsk_r [4][4];
    logic [255:0] dsk_nxt [4][4];
    logic [255:0] dsk_out [4];
    logic [3:0] gpf;
    logic [2:0] nfrag;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            rxl_pkg::ST_QUIET: if (i_link_on) st_nxt = rxl_pkg::ST_ALIGN;
            rxl_pkg::ST_ALIGN: if (i_train_done) st_nxt = rxl_pkg::ST_RUN;
            rxl_pkg::ST_RUN: st_nxt = rxl_pkg::ST_RUN;
            default: st_nxt = rxl_pkg::ST_QUIET;
        endcase
        if (!i_link_on) begin
            st_nxt = rxl_pkg::ST_QUIET;
        end
        // rising edge of the link clock, seen after the synchroniser
        take_nxt = lclk_s2_r && !lclk_s3_r && st_r != rxl_pkg::ST_QUIET;
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                dsk_nxt[s][d] = dsk_r[s][d];
            end
            if (take_nxt) begin
                dsk_nxt[s][0] = frag_s2_r[s*256 +: 256];
                for (int d = 1; d < 4; d++) begin
                    dsk_nxt[s][d] = dsk_r[s][d-1];
                end
            end
            dsk_out[s] = dsk_r[s][i_slice_dly[2*s +: 2]];
        end
        gpf = 4'(4'h2 << i_frag_w);
        nfrag = 3'(3'h1 << i_slices);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lclk_s1_r <= 1'b0;
            lclk_s2_r <= 1'b0;
            lclk_s3_r <= 1'b0;
            frag_s1_r <= '0;
            frag_s2_r <= '0;
            take_r <= 1'b0;
            st_r <= rxl_pkg::ST_QUIET;
            for (int s = 0; s < 4; s++) begin
                for (int d = 0; d < 4; d++) begin
                    dsk_r[s][d] <= '0;
                end
            end
        end else begin
            lclk_s1_r <= i_lnk_clk;
            lclk_s2_r <= lclk_s1_r;
            lclk_s3_r <= lclk_s2_r;
            frag_s1_r <= i_frag;
            frag_s2_r <= frag_s1_r;
            take_r <= take_nxt;
            st_r <= st_nxt;
            for (int s = 0; s < 4; s++) begin
                for (int d = 0; d < 4; d++) begin
                    dsk_r[s][d] <= dsk_nxt[s][d];
                end
            end
        end
    end

    // training checks
    logic [3:0] phase_r, phase_nxt;
    logic [31:0] skew_r, skew_nxt;

    always_comb begin
        phase_nxt = phase_r;
        skew_nxt = skew_r;
        if (st_r != rxl_pkg::ST_ALIGN) begin
            phase_nxt = 4'h0;
        end else if (take_r) begin
            for (int s = 0; s < 4; s++) begin
                phase_nxt[s] = (3'(s) < nfrag);
                for (int g = 0; g < 8; g++) begin
                    // value mod granules-per-fragment must equal index
                    if (4'(g) < gpf && (dsk_out[s][g*32 +: 8] & 8'(gpf - 4'h1)) != 8'(g)) begin
                        phase_nxt[s] = 1'b0;
                    end
                end
                // 8-bit difference wraps, read it as signed
                skew_nxt[s*8 +: 8] = dsk_out[s][7:0] - dsk_out[0][7:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_r <= 4'h0;
            skew_r <= 32'h0;
        end else begin
            phase_r <= phase_nxt;
            skew_r <= skew_nxt;
        end
    end

    // unpacking, steering and collection
    logic [31:0] llp_r [16];
    logic [31:0] llp_nxt [16];
    logic [31:0] wk_r [16];
    logic [31:0] wk_nxt [16];
    logic [31:0] col_r [16];
    logic [31:0] col_nxt [16];
    logic [4:0] fill_r, fill_nxt;
    logic [15:0] marks_r, marks_nxt;
    logic [3:0] widx_r, widx_nxt;
    logic wbusy_r, wbusy_nxt;
    logic col_on_r, col_on_nxt;
    logic [4:0] col_cnt_r, col_cnt_nxt, col_len_r, col_len_nxt;
    rxl_pkg::rxl_ttype_t col_typ_r, col_typ_nxt, cur_typ;
    logic [2:0] col_strm_r, col_strm_nxt;
    logic tv_r, tv_nxt, cv_r, cv_nxt, vv_r, vv_nxt;
    logic [2:0] ts_r, ts_nxt;
    logic [4:0] tl_r, tl_nxt;
    logic [511:0] td_r, td_nxt;
    logic [31:0] cd_r, cd_nxt, vd_r, vd_nxt, cur_g, hdr;
    logic cur_mark;
    int pos;

    always_comb begin
        llp_nxt = llp_r;
        wk_nxt = wk_r;
        col_nxt = col_r;
        fill_nxt = fill_r;
        marks_nxt = marks_r;
        widx_nxt = widx_r;
        wbusy_nxt = wbusy_r;
        col_on_nxt = col_on_r;
        col_cnt_nxt = col_cnt_r;
        col_len_nxt = col_len_r;
        col_typ_nxt = col_typ_r;
        col_strm_nxt = col_strm_r;
        tv_nxt = 1'b0;
        cv_nxt = 1'b0;
        vv_nxt = 1'b0;
        ts_nxt = ts_r;
        tl_nxt = tl_r;
        td_nxt = td_r;
        cd_nxt = cd_r;
        vd_nxt = vd_r;
        pos = 0;
        hdr = rxl_fix(llp_r[0]);
        cur_g = rxl_fix(wk_r[widx_r]);
        cur_mark = wbusy_r && marks_r[widx_r];
        cur_typ = rxl_pkg::rxl_ttype_t'(cur_g[`RXL_TYPE_LSB +: 2]);
        if (wbusy_r) begin
            if (cur_mark) begin
                col_on_nxt = (cur_typ != rxl_pkg::TT_IDLE);
                col_cnt_nxt = 5'h01;
                col_nxt[0] = cur_g;
                col_len_nxt = (cur_g[`RXL_LEN_LSB +: 4] == 4'h0) ? 5'h10 : {1'b0, cur_g[`RXL_LEN_LSB +: 4]};
                col_typ_nxt = cur_typ;
                col_strm_nxt = cur_g[`RXL_STRM_LSB +: 3];
            end else if (col_on_r) begin
                col_nxt[col_cnt_r[3:0]] = cur_g;
                col_cnt_nxt = col_cnt_r + 5'h01;
            end
            // hand over only once every granule is in
            if (col_on_nxt && col_cnt_nxt == col_len_nxt) begin
                col_on_nxt = 1'b0;
                unique case (col_typ_nxt)
                    rxl_pkg::TT_CREDIT: begin
                        cv_nxt = 1'b1;
                        cd_nxt = col_nxt[0];
                    end
                    rxl_pkg::TT_VWIRE: begin
                        vv_nxt = 1'b1;
                        vd_nxt = col_nxt[0];
                    end
                    default: begin
                        tv_nxt = 1'b1;
                        ts_nxt = col_strm_nxt;
                        tl_nxt = col_len_nxt;
                        for (int i = 0; i < 16; i++) begin
                            td_nxt[i*32 +: 32] = col_nxt[i];
                        end
                    end
                endcase
            end
            widx_nxt = widx_r + 4'h1;
            wbusy_nxt = (widx_r != 4'hF);
        end
        if (take_r && st_r == rxl_pkg::ST_RUN) begin
            for (int f = 0; f < 4; f++) begin
                for (int s = 0; s < 8; s++) begin
                    if (3'(f) < nfrag && 4'(s) < gpf) begin
                        // 1xN and 2x64 run in order, wider multi-slice bundles interleave
                        if (nfrag == 3'h1 || (nfrag == 3'h2 && gpf == 4'h2)) begin
                            pos = f * int'(gpf) + s;
                        end else begin
                            pos = f + int'(nfrag) * s;
                        end
                        llp_nxt[4'(int'(fill_r) + pos)] = dsk_out[f][s*32 +: 32];
                    end
                end
            end
            fill_nxt = 5'(int'(fill_r) + int'(nfrag) * int'(gpf));
            if (fill_nxt == 5'h10) begin
                fill_nxt = 5'h00;
                wk_nxt = llp_nxt;
                hdr = rxl_fix(llp_nxt[0]);
                marks_nxt = {hdr[`RXL_MARK_LSB +: 15], 1'b0};
                widx_nxt = 4'h1;
                wbusy_nxt = 1'b1;
            end
        end
        if (st_r != rxl_pkg::ST_RUN) begin
            fill_nxt = 5'h00;
            wbusy_nxt = 1'b0;
            col_on_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 16; i++) begin
                llp_r[i] <= 32'h0;
                wk_r[i] <= 32'h0;
                col_r[i] <= 32'h0;
            end
            fill_r <= 5'h00;
            marks_r <= 16'h0;
            widx_r <= 4'h0;
            wbusy_r <= 1'b0;
            col_on_r <= 1'b0;
            col_cnt_r <= 5'h00;
            col_len_r <= 5'h00;
            col_typ_r <= rxl_pkg::TT_IDLE;
            col_strm_r <= 3'h0;
            tv_r <= 1'b0;
            cv_r <= 1'b0;
            vv_r <= 1'b0;
            ts_r <= 3'h0;
            tl_r <= 5'h00;
            td_r <= '0;
            cd_r <= 32'h0;
            vd_r <= 32'h0;
        end else begin
            llp_r <= llp_nxt;
            wk_r <= wk_nxt;
            col_r <= col_nxt;
            fill_r <= fill_nxt;
            marks_r <= marks_nxt;
            widx_r <= widx_nxt;
            wbusy_r <= wbusy_nxt;
            col_on_r <= col_on_nxt;
            col_cnt_r <= col_cnt_nxt;
            col_len_r <= col_len_nxt;
            col_typ_r <= col_typ_nxt;
            col_strm_r <= col_strm_nxt;
            tv_r <= tv_nxt;
            cv_r <= cv_nxt;
            vv_r <= vv_nxt;
            ts_r <= ts_nxt;
            tl_r <= tl_nxt;
            td_r <= td_nxt;
            cd_r <= cd_nxt;
            vd_r <= vd_nxt;
        end
    end

    assign o_state = st_r;
    assign o_phase_ok = phase_r;
    assign o_skew = skew_r;
    assign o_tlp_valid = tv_r;
    assign o_tlp_stream = ts_r;
    assign o_tlp_len = tl_r;
    assign o_tlp_data = td_r;
    assign o_credit_valid = cv_r;
    assign o_credit_data = cd_r;
    assign o_vw_valid = vv_r;
    assign o_vw_data = vd_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_single(rxl_pkg::rxl_ttype_t t);
        cur_mark && cur_typ == t && cur_g[`RXL_LEN_LSB +: 4] == 4'h1;
    endsequence

    property p_quiet_hold;
        st_r == rxl_pkg::ST_QUIET |=> $stable(dsk_r[0][0]) && !take_r;
    endproperty
    a_quiet_hold: assert property (p_quiet_hold) else $error("fragment captured while quiet");
    property p_phase64;
        st_r == rxl_pkg::ST_ALIGN && take_r && i_frag_w == rxl_pkg::FW_64 && dsk_out[0][0] |=> !o_phase_ok[0];
    endproperty
    a_phase64: assert property (p_phase64) else $error("odd granule 0 passed phase");
    property p_phase_state;
        o_phase_ok != 4'h0 |-> $past(st_r) == rxl_pkg::ST_ALIGN;
    endproperty
    a_phase_state: assert property (p_phase_state) else $error("phase ok outside alignment");
    property p_skew_zero;
        st_r == rxl_pkg::ST_ALIGN && take_r && dsk_out[1][7:0] == dsk_out[0][7:0] |=> o_skew[15:8] == 8'h00;
    endproperty
    a_skew_zero: assert property (p_skew_zero) else $error("equal bytes gave skew");
    property p_credit;
        s_single(rxl_pkg::TT_CREDIT) |=> o_credit_valid && !o_tlp_valid ##1 (!o_credit_valid || $past(cur_mark));
    endproperty
    a_credit: assert property (p_credit) else $error("credit packet not forwarded");
    property p_vwire;
        s_single(rxl_pkg::TT_VWIRE) |=> o_vw_valid && o_vw_data == $past(cur_g);
    endproperty
    a_vwire: assert property (p_vwire) else $error("virtual wire packet not routed");
    property p_idle_drop;
        cur_mark && cur_typ == rxl_pkg::TT_IDLE |=> !o_tlp_valid && !o_credit_valid && !o_vw_valid;
    endproperty
    a_idle_drop: assert property (p_idle_drop) else $error("idle filler delivered");
    property p_fill_1x64;
        take_r && st_r == rxl_pkg::ST_RUN && nfrag == 3'h1 && gpf == 4'h2 && fill_r == 5'h0E
            |=> wbusy_r && widx_r == 4'h1 && fill_r == 5'h00;
    endproperty
    a_fill_1x64: assert property (p_fill_1x64) else $error("link packet not complete after 8 fragments");

endmodule : rxl_top

// [verification/rxl_far_tx.sv]
`timescale 1ns/100ps
module rxl_far_tx (
    // link toward the receiver
    output logic o_lnk_clk,
    output logic [1023:0] o_frag
);
    // lanes are taken as already trained, so beats are clean from the start
    initial begin
        o_lnk_clk = 1'b0;
        o_frag = '0;
    end

    // edges kept 7 ns off the system clock grid; clock stands low between beats
    task automatic send(input logic [1023:0] beat);
        #7;
        o_frag = beat;
        #160 o_lnk_clk = 1'b1;
        #160 o_lnk_clk = 1'b0;
        // released lines show the inverse, never stale data
        o_frag = ~beat;
    endtask : send

    // replicated wrapping count; offs skews each slice; unused bits zero
    task automatic train(input int ns, input int gpf, input int n, input logic [7:0] v0, input logic [31:0] offs);
        logic [1023:0] bt;
        logic [7:0] v;
        for (int b = 0; b < n; b++) begin
            bt = '0;
            for (int s = 0; s < ns; s++) begin
                for (int g = 0; g < gpf; g++) begin
                    v = v0 + 8'(b * gpf + g) + offs[8*s +: 8];
                    bt[256*s + 32*g +: 32] = {4{v}};
                end
            end
            send(bt);
        end
    endtask : train

    // header in fragment zero bits 31:0; only 1xN and 2x64 run in order
    task automatic send_llp(input logic [511:0] g, input int ns, input int gpf);
        logic [1023:0] bt;
        int pos;
        for (int b = 0; b < 16 / (ns * gpf); b++) begin
            bt = '0;
            for (int f = 0; f < ns; f++) begin
                for (int s = 0; s < gpf; s++) begin
                    pos = (ns == 1 || (ns == 2 && gpf == 2)) ? f * gpf + s : f + ns * s;
                    bt[256*f + 32*s +: 32] = g[32*(b*ns*gpf + pos) +: 32];
                end
            end
            send(bt);
        end
    endtask : send_llp
endmodule : rxl_far_tx

// [verification/rxl_top_test.sv]
`timescale 1ns/100ps
module rxl_top_test;
    logic i_clk, i_rst_b, i_link_on, i_train_done;
    logic [1:0] i_frag_w, i_slices;
    logic [7:0] i_slice_dly;
    logic lnk_clk;
    logic [1023:0] frag;
    logic [1:0] o_state;
    logic [3:0] o_phase_ok;
    logic [31:0] o_skew, o_credit_data, o_vw_data;
    logic o_tlp_valid, o_credit_valid, o_vw_valid;
    logic [2:0] o_tlp_stream;
    logic [4:0] o_tlp_len;
    logic [511:0] o_tlp_data;
    int n_errors, num_checks, cyc, n_tlp, n_cr, n_vw;

    rxl_far_tx u_rxl_far_tx (.o_lnk_clk(lnk_clk), .o_frag(frag));
    rxl_top u_rxl_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_frag_w(i_frag_w), .i_slices(i_slices),
        .i_link_on(i_link_on), .i_train_done(i_train_done), .i_slice_dly(i_slice_dly), .i_lnk_clk(lnk_clk),
        .i_frag(frag), .o_state(o_state), .o_phase_ok(o_phase_ok), .o_skew(o_skew), .o_tlp_valid(o_tlp_valid),
        .o_tlp_stream(o_tlp_stream), .o_tlp_len(o_tlp_len), .o_tlp_data(o_tlp_data),
        .o_credit_valid(o_credit_valid), .o_credit_data(o_credit_data), .o_vw_valid(o_vw_valid),
        .o_vw_data(o_vw_data));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc++;
        n_tlp += (o_tlp_valid === 1'b1);
        n_cr += (o_credit_valid === 1'b1);
        n_vw += (o_vw_valid === 1'b1);
        if (cyc == 8000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [511:0] seen, input logic [511:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // parity bits at positions 1,2,4,8,16 zero the syndrome
    function automatic logic [31:0] enc(input logic [31:0] w);
        logic [4:0] syn;
        w = w & ~32'h0001_0116;
        syn = 5'h00;
        for (int i = 1; i < 32; i++) if (w[i]) syn ^= 5'(i);
        for (int k = 0; k < 5; k++) if (syn[k]) w[1 << k] = 1'b1;
        return w;
    endfunction : enc

    task automatic enter_align(input logic [1:0] fw, input logic [1:0] ns);
        @(posedge i_clk);
        i_link_on <= 1'b0;
        i_train_done <= 1'b0;
        repeat (3) @(posedge i_clk);
        check({o_state, o_phase_ok}, 6'h00);
        i_frag_w <= fw;
        i_slices <= ns;
        i_slice_dly <= 8'h00;
        i_link_on <= 1'b1;
        repeat (2) @(posedge i_clk);
        check(o_state, rxl_pkg::ST_ALIGN);
    endtask : enter_align

    task automatic t_quiet;
        u_rxl_far_tx.train(1, 2, 3, 8'h00, 32'h0);
        check({o_state, o_phase_ok, o_skew}, 38'h0);
    endtask : t_quiet

    task automatic t_phase;
        int gpf;
        for (int fw = 0; fw < 3; fw++) begin
            gpf = 2 << fw;
            enter_align(2'(fw), rxl_pkg::NS_1);
            u_rxl_far_tx.train(1, gpf, 4, 8'hF0, 32'h0);
            repeat (4) @(posedge i_clk);
            check(o_phase_ok, 4'h1);
            u_rxl_far_tx.train(1, gpf, 2, 8'h01, 32'h0);
            repeat (4) @(posedge i_clk);
            check(o_phase_ok, 4'h0);
            // phase fixed on the far side, receiver must report it good again
            u_rxl_far_tx.train(1, gpf, 2, 8'h10, 32'h0);
            repeat (4) @(posedge i_clk);
            check(o_phase_ok, 4'h1);
        end
    endtask : t_phase

    // slice 1 one beat early, slice 2 one beat late, across the 0xFF wrap
    task automatic t_skew;
        enter_align(rxl_pkg::FW_128, rxl_pkg::NS_4);
        u_rxl_far_tx.train(4, 4, 4, 8'hF8, 32'h00FC_0400);
        repeat (4) @(posedge i_clk);
        check({o_phase_ok, o_skew}, 36'hF_00FC_0400);
        i_slice_dly <= 8'h49;
        u_rxl_far_tx.train(4, 4, 5, 8'h08, 32'h00FC_0400);
        repeat (4) @(posedge i_clk);
        check(o_skew, 32'h0);
    endtask : t_skew

    task automatic t_run(input logic [1:0] fw, input logic [1:0] ns, input int gpf);
        logic [511:0] g;
        logic [31:0] cr, dh, p1, p2, vw;
        cr = enc(32'h0000_1040);
        dh = enc(32'h0000_3A20);
        p1 = enc(32'hDEAD_BE00);
        p2 = enc(32'h1234_5600);
        vw = enc(32'h0000_1060);
        g = {9{enc(32'hA5A5_A500)}};
        g = {g[287:0], vw, enc(32'h0000_1000), p2, p1 ^ 32'h4000_0000, dh ^ 32'h0000_0400, cr,
            enc(32'h0066_0000) ^ 32'h0010_0000};
        enter_align(fw, ns);
        i_train_done <= 1'b1;
        repeat (2) @(posedge i_clk);
        check(o_state, rxl_pkg::ST_RUN);
        n_tlp = 0;
        n_cr = 0;
        n_vw = 0;
        u_rxl_far_tx.send_llp(g, 1 << ns, gpf);
        repeat (24) @(posedge i_clk);
        check({o_tlp_stream, o_tlp_len, o_tlp_data[95:0]}, {3'd5, 5'd3, p2, p1, dh});
        check({o_credit_data, o_vw_data}, {cr, vw});
        check({n_tlp, n_cr, n_vw}, {32'd1, 32'd1, 32'd1});
    endtask : t_run

    initial begin
        i_rst_b = 1'b0;
        i_link_on = 1'b0;
        i_train_done = 1'b0;
        i_frag_w = rxl_pkg::FW_64;
        i_slices = rxl_pkg::NS_1;
        i_slice_dly = 8'h00;
        n_errors = 0;
        num_checks = 0;
        cyc = 0;
        repeat (6) @(posedge i_clk);
        check({o_state, o_phase_ok, o_skew, o_tlp_valid, o_credit_valid, o_vw_valid}, 41'h0);
        i_rst_b <= 1'b1;
        t_quiet();
        t_phase();
        t_skew();
        t_run(rxl_pkg::FW_256, rxl_pkg::NS_1, 8);
        t_run(rxl_pkg::FW_128, rxl_pkg::NS_2, 4);
        t_run(rxl_pkg::FW_64, rxl_pkg::NS_1, 2);
        t_run(rxl_pkg::FW_64, rxl_pkg::NS_4, 2);
        tally_and_finish();
    end
endmodule : rxl_top_test
